// >>> design/ctp_pkg.sv
package ctp_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_SCER = 8'h00;
  localparam logic [7:0] OFF_SCDR = 8'h04;
  localparam logic [7:0] OFF_SCSR = 8'h08;
  localparam logic [7:0] OFF_PCER = 8'h10;
  localparam logic [7:0] OFF_PCDR = 8'h14;
  localparam logic [7:0] OFF_PCSR = 8'h18;
  localparam logic [7:0] OFF_MOR = 8'h20;
  localparam logic [7:0] OFF_PLL1 = 8'h28;
  localparam logic [7:0] OFF_PLL2 = 8'h2C;
  localparam logic [7:0] OFF_MCKR = 8'h30;
  localparam logic [7:0] OFF_PCK0 = 8'h40;
  localparam logic [7:0] OFF_PCK1 = 8'h44;
  localparam logic [7:0] OFF_IER = 8'h60;
  localparam logic [7:0] OFF_IDR = 8'h64;
  localparam logic [7:0] OFF_SR = 8'h68;
  localparam logic [7:0] OFF_IMR = 8'h6C;
  // oscillator register fields
  localparam int MOR_EN_BIT = 0;
  localparam int MOR_CNT_LSB = 8;
  localparam int MOR_CNT_W = 8;
  // pll register fields
  localparam int PLL_DIV_LSB = 0;
  localparam int PLL_DIV_W = 8;
  localparam int PLL_CNT_LSB = 8;
  localparam int PLL_CNT_W = 6;
  localparam int PLL_RNG_LSB = 14;
  localparam int PLL_RNG_W = 2;
  localparam int PLL_MUL_LSB = 16;
  localparam int PLL1_MUL_W = 8;
  localparam int PLL2_MUL_W = 11;
  localparam int USB_DIV_LSB = 28;
  localparam int USB_DIV_W = 2;
  // master and programmable clock fields
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 2;
  localparam int P2DIV_LSB = 2;
  localparam int P2DIV_W = 3;
  localparam int RATIO_LSB = 8;
  localparam int RATIO_W = 2;
  localparam int HALVE_BIT = 12;
  localparam int MCK_OPT_BIT = 8;
  localparam int FACT_W = 7;
  // status and system clock bits
  localparam int SR_OSC = 0;
  localparam int SR_LOCK1 = 1;
  localparam int SR_LOCK2 = 2;
  localparam int SR_MRDY = 3;
  localparam int SR_PCKRDY_LSB = 8;
  localparam int SC_PCK_LSB = 8;
  // clock source codes
  localparam logic [1:0] SRC_SLOW = 2'h0;
  localparam logic [1:0] SRC_MAIN = 2'h1;
  localparam logic [1:0] SRC_PLL1 = 2'h2;
  localparam logic [1:0] SRC_PLL2 = 2'h3;
  // reset values and settling counts in slow clock cycles
  localparam logic [PLL_CNT_W-1:0] PLL_CNT_RST = 6'h3F;
  localparam logic [3:0] MCK_SWITCH_TICKS = 4'h4;
  localparam logic [3:0] PCK_SETTLE_TICKS = 4'h2;
  localparam logic [2:0] RATIO_THREE = 3'h3;
  localparam logic [1:0] RATIO_CODE_THREE = 2'h3;
  localparam logic [FACT_W-1:0] FACT_ONE = 7'h01;
endpackage

// >>> design/ctp_clock_tree.sv
// Local design decisions: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
module ctp_clock_tree
  import ctp_pkg::*;
#(
  parameter int N_PERIPH = 19,
  parameter int N_PCK = 2
)(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // slow clock pin, used as a timebase
  input wire logic slow_clk_i,
  // avalon-mm slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // oscillator and plls
  output logic osc_enable_o,
  output logic pll1_on_o,
  output logic [PLL1_MUL_W-1:0] pll1_mul_o,
  output logic [PLL_DIV_W-1:0] pll1_div_o,
  output logic [PLL_RNG_W-1:0] pll1_range_o,
  output logic pll2_on_o,
  output logic [PLL2_MUL_W-1:0] pll2_mul_o,
  output logic [PLL_DIV_W-1:0] pll2_div_o,
  output logic [PLL_RNG_W-1:0] pll2_range_o,
  output logic [2:0] usb_div_factor_o,
  // master clock
  output logic [1:0] master_src_o,
  output logic [FACT_W-1:0] master_presc_o,
  output logic [2:0] master_ratio_o,
  output logic [1:0] pll1_halve_factor_o,
  // programmable and peripheral clocks
  output logic [N_PCK-1:0] prog_clk_en_o,
  output logic [3*N_PCK-1:0] prog_src_o,
  output logic [FACT_W*N_PCK-1:0] prog_presc_o,
  output logic [N_PERIPH-1:0] periph_clk_en_o,
  // interrupt
  output logic irq_o
);

  localparam int SR_W = SR_PCKRDY_LSB + N_PCK;

  ////////////////////////////////////////////////////////////////////////////
  // slow clock synchroniser and tick
  logic slck_meta_reg, slck_sync_reg, slck_last_reg, slow_tick;
  always_ff @(posedge sys_clk_i)
  begin
    slck_meta_reg <= slow_clk_i;
    slck_sync_reg <= slck_meta_reg;
    slck_last_reg <= slck_sync_reg;
  end
  assign slow_tick = slck_sync_reg & ~slck_last_reg;

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait state per access
  logic ack_reg, wr_fire, rd_first;
  logic [31:0] wmask, cur_word, merged, rdata_reg;
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;
  assign wr_fire = avs_write_i & ack_reg;
  assign rd_first = avs_read_i & ~ack_reg;
  assign wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                  {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign merged = (cur_word & ~wmask) | (avs_writedata_i & wmask);
  assign avs_readdata_o = rdata_reg;
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= '0;
    end
    else
    begin
      ack_reg <= (avs_read_i | avs_write_i) & ~ack_reg;
      if (rd_first)
        rdata_reg <= cur_word;
    end
  end

  logic wr_scer, wr_scdr, wr_pcer, wr_pcdr, wr_mor, wr_pll1, wr_pll2;
  logic wr_mckr, wr_ier, wr_idr;
  logic [N_PCK-1:0] wr_pck;
  logic [31:0] wset;
  assign wset = avs_writedata_i & wmask;
  assign wr_scer = wr_fire & (avs_address_i == OFF_SCER);
  assign wr_scdr = wr_fire & (avs_address_i == OFF_SCDR);
  assign wr_pcer = wr_fire & (avs_address_i == OFF_PCER);
  assign wr_pcdr = wr_fire & (avs_address_i == OFF_PCDR);
  assign wr_mor = wr_fire & (avs_address_i == OFF_MOR);
  assign wr_pll1 = wr_fire & (avs_address_i == OFF_PLL1);
  assign wr_pll2 = wr_fire & (avs_address_i == OFF_PLL2);
  assign wr_mckr = wr_fire & (avs_address_i == OFF_MCKR);
  assign wr_ier = wr_fire & (avs_address_i == OFF_IER);
  assign wr_idr = wr_fire & (avs_address_i == OFF_IDR);
  assign wr_pck[0] = wr_fire & (avs_address_i == OFF_PCK0);
  assign wr_pck[1] = wr_fire & (avs_address_i == OFF_PCK1);

  ////////////////////////////////////////////////////////////////////////////
  // main oscillator
  logic osc_en_reg, osc_stable_reg, osc_boot_reg, osc_expire;
  logic [MOR_CNT_W-1:0] osc_cnt_reg;
  ctp_tick_timer #(.W(MOR_CNT_W)) u_osc_timer (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .start_i(osc_boot_reg | (wr_mor & merged[MOR_EN_BIT])),
    .load_i(wr_mor ? merged[MOR_CNT_LSB +: MOR_CNT_W] : osc_cnt_reg),
    .tick_i(slow_tick), .expire_o(osc_expire));
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      osc_en_reg <= 1'b1;
      osc_cnt_reg <= '0;
      osc_boot_reg <= 1'b1;
      osc_stable_reg <= 1'b0;
    end
    else
    begin
      osc_boot_reg <= 1'b0;
      if (wr_mor)
      begin
        osc_en_reg <= merged[MOR_EN_BIT];
        osc_cnt_reg <= merged[MOR_CNT_LSB +: MOR_CNT_W];
      end
      if (wr_mor & ~merged[MOR_EN_BIT])
        osc_stable_reg <= 1'b0;
      else if (osc_expire & osc_en_reg)
        osc_stable_reg <= 1'b1;
    end
  end
  assign osc_enable_o = osc_en_reg;

  ////////////////////////////////////////////////////////////////////////////
  // two plls: register fields, lock timers and lock flags
  logic [PLL1_MUL_W-1:0] pll1_mul_reg;
  logic [PLL2_MUL_W-1:0] pll2_mul_reg;
  logic [PLL_DIV_W-1:0] pll1_div_reg, pll2_div_reg;
  logic [PLL_CNT_W-1:0] pll1_cnt_reg, pll2_cnt_reg;
  logic [PLL_RNG_W-1:0] pll1_rng_reg, pll2_rng_reg;
  logic [USB_DIV_W-1:0] usb_div_reg;
  logic lock1_reg, lock2_reg, pll1_expire, pll2_expire, pll1_chg, pll2_chg;
  logic lock1_set;
  assign pll1_on_o = (pll1_mul_reg != '0) & (pll1_div_reg != '0);
  assign pll2_on_o = (pll2_mul_reg != '0) & (pll2_div_reg != '0);
  assign pll1_chg = wr_pll1 &
    ((merged[PLL_MUL_LSB +: PLL1_MUL_W] != pll1_mul_reg) |
     (merged[PLL_DIV_LSB +: PLL_DIV_W] != pll1_div_reg));
  assign pll2_chg = wr_pll2 &
    ((merged[PLL_MUL_LSB +: PLL2_MUL_W] != pll2_mul_reg) |
     (merged[PLL_DIV_LSB +: PLL_DIV_W] != pll2_div_reg));
  assign lock1_set = pll1_expire & pll1_on_o & ~lock1_reg;
  ctp_tick_timer #(.W(PLL_CNT_W)) u_pll1_timer (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .start_i(wr_pll1),
    .load_i(merged[PLL_CNT_LSB +: PLL_CNT_W]),
    .tick_i(slow_tick), .expire_o(pll1_expire));
  ctp_tick_timer #(.W(PLL_CNT_W)) u_pll2_timer (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .start_i(wr_pll2),
    .load_i(merged[PLL_CNT_LSB +: PLL_CNT_W]),
    .tick_i(slow_tick), .expire_o(pll2_expire));
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      pll1_mul_reg <= '0;
      pll1_div_reg <= '0;
      pll1_cnt_reg <= PLL_CNT_RST;
      pll1_rng_reg <= '0;
    end
    else if (wr_pll1)
    begin
      pll1_mul_reg <= merged[PLL_MUL_LSB +: PLL1_MUL_W];
      pll1_div_reg <= merged[PLL_DIV_LSB +: PLL_DIV_W];
      pll1_cnt_reg <= merged[PLL_CNT_LSB +: PLL_CNT_W];
      pll1_rng_reg <= merged[PLL_RNG_LSB +: PLL_RNG_W];
    end
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      pll2_mul_reg <= '0;
      pll2_div_reg <= '0;
      pll2_cnt_reg <= PLL_CNT_RST;
      pll2_rng_reg <= '0;
      usb_div_reg <= '0;
    end
    else if (wr_pll2)
    begin
      pll2_mul_reg <= merged[PLL_MUL_LSB +: PLL2_MUL_W];
      pll2_div_reg <= merged[PLL_DIV_LSB +: PLL_DIV_W];
      pll2_cnt_reg <= merged[PLL_CNT_LSB +: PLL_CNT_W];
      pll2_rng_reg <= merged[PLL_RNG_LSB +: PLL_RNG_W];
      usb_div_reg <= merged[USB_DIV_LSB +: USB_DIV_W];
    end
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i | pll1_chg | ~pll1_on_o)
      lock1_reg <= 1'b0;
    else if (pll1_expire)
      lock1_reg <= 1'b1;
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i | pll2_chg | ~pll2_on_o)
      lock2_reg <= 1'b0;
    else if (pll2_expire)
      lock2_reg <= 1'b1;
  end
  assign pll1_mul_o = pll1_mul_reg;
  assign pll1_div_o = pll1_div_reg;
  assign pll1_range_o = pll1_rng_reg;
  assign pll2_mul_o = pll2_mul_reg;
  assign pll2_div_o = pll2_div_reg;
  assign pll2_range_o = pll2_rng_reg;
  assign usb_div_factor_o = usb_div_reg[1] ? 3'h4 : (usb_div_reg[0] ? 3'h2
                            : 3'h1);

  ////////////////////////////////////////////////////////////////////////////
  // master clock selection, prescaler and ready flag
  logic [1:0] sel_reg, ratio_reg;
  logic [P2DIV_W-1:0] p2div_reg;
  logic halve_reg, mck_rdy_reg, mck_chg, mck_fallback, mck_expire;
  assign mck_chg = wr_mckr &
    ((merged[SEL_LSB +: SEL_W] != sel_reg) |
     (merged[P2DIV_LSB +: P2DIV_W] != p2div_reg));
  assign mck_fallback = (sel_reg == SRC_PLL1) & ~lock1_reg;
  ctp_tick_timer #(.W(4)) u_mck_timer (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .start_i(mck_chg | (lock1_set & (sel_reg == SRC_PLL1))),
    .load_i(MCK_SWITCH_TICKS), .tick_i(slow_tick), .expire_o(mck_expire));
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      sel_reg <= SRC_MAIN;
      p2div_reg <= '0;
      ratio_reg <= '0;
      halve_reg <= 1'b0;
    end
    else if (wr_mckr)
    begin
      sel_reg <= merged[SEL_LSB +: SEL_W];
      p2div_reg <= merged[P2DIV_LSB +: P2DIV_W];
      ratio_reg <= merged[RATIO_LSB +: RATIO_W];
      halve_reg <= merged[HALVE_BIT];
    end
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      mck_rdy_reg <= 1'b1;
    else if (mck_chg | mck_fallback)
      mck_rdy_reg <= 1'b0;
    else if (mck_expire)
      mck_rdy_reg <= 1'b1;
  end
  assign master_src_o = mck_fallback ? SRC_MAIN : sel_reg;
  assign master_presc_o = FACT_W'(FACT_ONE << p2div_reg);
  assign master_ratio_o = (ratio_reg == RATIO_CODE_THREE) ? RATIO_THREE
                          : 3'(3'h1 << ratio_reg);
  assign pll1_halve_factor_o = halve_reg ? 2'h2 : 2'h1;

  ////////////////////////////////////////////////////////////////////////////
  // programmable clocks
  logic [N_PCK-1:0] pck_en_reg, pck_rdy_reg;
  genvar gi;
  generate
    for (gi = 0; gi < N_PCK; gi++)
    begin : g_pck
      logic [2:0] src_reg;
      logic [P2DIV_W-1:0] p2div_p_reg;
      logic en_set, en_clr, restart, expire;
      assign en_set = wr_scer & wset[SC_PCK_LSB + gi];
      assign en_clr = wr_scdr & wset[SC_PCK_LSB + gi];
      assign restart = (en_set & ~pck_en_reg[gi]) |
                       (wr_pck[gi] & pck_en_reg[gi]);
      ctp_tick_timer #(.W(4)) u_pck_timer (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .start_i(restart),
        .load_i(PCK_SETTLE_TICKS), .tick_i(slow_tick), .expire_o(expire));
      always_ff @(posedge sys_clk_i)
      begin
        if (rst_i)
        begin
          src_reg <= {1'b0, SRC_SLOW};
          p2div_p_reg <= '0;
        end
        else if (wr_pck[gi])
        begin
          src_reg <= {merged[MCK_OPT_BIT], merged[SEL_LSB +: SEL_W]};
          p2div_p_reg <= merged[P2DIV_LSB +: P2DIV_W];
        end
      end
      always_ff @(posedge sys_clk_i)
      begin
        if (rst_i | en_clr)
          pck_en_reg[gi] <= 1'b0;
        else if (en_set)
          pck_en_reg[gi] <= 1'b1;
      end
      always_ff @(posedge sys_clk_i)
      begin
        if (rst_i | en_clr | restart)
          pck_rdy_reg[gi] <= 1'b0;
        else if (expire & pck_en_reg[gi])
          pck_rdy_reg[gi] <= 1'b1;
      end
      assign prog_src_o[3*gi +: 3] = src_reg;
      assign prog_presc_o[FACT_W*gi +: FACT_W] =
        FACT_W'(FACT_ONE << p2div_p_reg);
    end
  endgenerate
  assign prog_clk_en_o = pck_en_reg;

  ////////////////////////////////////////////////////////////////////////////
  // peripheral clocks, status and interrupt mask
  logic [N_PERIPH-1:0] periph_en_reg;
  logic [SR_W-1:0] sr_bits, imr_reg;
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      periph_en_reg <= '0;
    else if (wr_pcer | wr_pcdr)
      periph_en_reg <= wr_pcer ? (periph_en_reg | wset[N_PERIPH-1:0])
                       : (periph_en_reg & ~wset[N_PERIPH-1:0]);
  end
  assign periph_clk_en_o = periph_en_reg;
  assign sr_bits = {pck_rdy_reg, {(SR_PCKRDY_LSB - SR_MRDY - 1){1'b0}},
                    mck_rdy_reg, lock2_reg, lock1_reg, osc_stable_reg};
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      imr_reg <= '0;
    else if (wr_ier | wr_idr)
      imr_reg <= wr_ier ? (imr_reg | wset[SR_W-1:0])
                 : (imr_reg & ~wset[SR_W-1:0]);
  end
  assign irq_o = |(sr_bits & imr_reg);

  ////////////////////////////////////////////////////////////////////////////
  // read data selection; unmapped offsets read zero
  assign cur_word =
    (avs_address_i == OFF_SCSR) ? 32'(pck_en_reg) << SC_PCK_LSB :
    (avs_address_i == OFF_PCSR) ? 32'(periph_en_reg) :
    (avs_address_i == OFF_MOR) ? (32'(osc_cnt_reg) << MOR_CNT_LSB) |
      (32'(osc_en_reg) << MOR_EN_BIT) :
    (avs_address_i == OFF_PLL1) ? (32'(pll1_mul_reg) << PLL_MUL_LSB) |
      (32'(pll1_rng_reg) << PLL_RNG_LSB) | (32'(pll1_cnt_reg) << PLL_CNT_LSB)
      | (32'(pll1_div_reg) << PLL_DIV_LSB) :
    (avs_address_i == OFF_PLL2) ? (32'(usb_div_reg) << USB_DIV_LSB) |
      (32'(pll2_mul_reg) << PLL_MUL_LSB) | (32'(pll2_rng_reg) << PLL_RNG_LSB)
      | (32'(pll2_cnt_reg) << PLL_CNT_LSB) | (32'(pll2_div_reg) << PLL_DIV_LSB) :
    (avs_address_i == OFF_MCKR) ? (32'(halve_reg) << HALVE_BIT) |
      (32'(ratio_reg) << RATIO_LSB) | (32'(p2div_reg) << P2DIV_LSB) |
      (32'(sel_reg) << SEL_LSB) :
    (avs_address_i == OFF_PCK0) ? (32'(g_pck[0].src_reg[2]) << MCK_OPT_BIT) |
      (32'(g_pck[0].p2div_p_reg) << P2DIV_LSB) |
      (32'(g_pck[0].src_reg[1:0]) << SEL_LSB) :
    (avs_address_i == OFF_PCK1) ? (32'(g_pck[1].src_reg[2]) << MCK_OPT_BIT) |
      (32'(g_pck[1].p2div_p_reg) << P2DIV_LSB) |
      (32'(g_pck[1].src_reg[1:0]) << SEL_LSB) :
    (avs_address_i == OFF_SR) ? 32'(sr_bits) :
    (avs_address_i == OFF_IMR) ? 32'(imr_reg) : '0;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence seq_pll1_rewrite;
    pll1_chg;
  endsequence
  sequence seq_mck_switch;
    mck_chg ##1 !mck_rdy_reg;
  endsequence
  chk_pll1_lock_drop: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    seq_pll1_rewrite |=> !lock1_reg) else $error("lock kept on pll change");
  chk_pll1_lock_off: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    lock1_reg |-> pll1_on_o) else $error("lock while pll off");
  chk_pll1_lock_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (pll1_expire && pll1_on_o && !pll1_chg) |=> lock1_reg)
    else $error("lock not set after count");
  chk_mck_fallback_main: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    mck_fallback |-> (master_src_o == SRC_MAIN) ##1 !mck_rdy_reg)
    else $error("no fallback to main clock");
  chk_mck_ready_clear: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    mck_chg && !mck_expire |-> seq_mck_switch)
    else $error("ready not cleared on switch");
  chk_master_ratio_map: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    (wr_mckr && (merged[RATIO_LSB +: RATIO_W] == RATIO_CODE_THREE))
      |=> (master_ratio_o == RATIO_THREE))
    else $error("ratio three wrong");
  chk_periph_enable_set: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    wr_pcer |=> ((periph_en_reg & $past(wset[N_PERIPH-1:0]))
                 == $past(wset[N_PERIPH-1:0])))
    else $error("peripheral clock not enabled");
  chk_pck_ready_en: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    pck_rdy_reg[0] |-> pck_en_reg[0]) else $error("ready while disabled");
  chk_osc_stable_en: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    $rose(osc_stable_reg) |-> $past(osc_expire) && osc_en_reg)
    else $error("oscillator flag without startup");

endmodule // ctp_clock_tree

////////////////////////////////////////////////////////////////////////////
// slow tick countdown: expires on the tick after load reaches zero
module ctp_tick_timer #(
  parameter int W = 8
)(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [W-1:0] load_i,
  input wire logic tick_i,
  output logic expire_o
);
  logic [W-1:0] cnt_reg;
  logic busy_reg;
  assign expire_o = busy_reg & tick_i & (cnt_reg == '0) & ~start_i;
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      cnt_reg <= '0;
      busy_reg <= 1'b0;
    end
    else if (start_i)
    begin
      cnt_reg <= load_i;
      busy_reg <= 1'b1;
    end
    else if (busy_reg & tick_i)
    begin
      if (cnt_reg == '0)
        busy_reg <= 1'b0;
      else
        cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule // ctp_tick_timer

// >>> verification/ctp_clock_tree_tb_top.sv
`timescale 1ns/1ps
module ctp_clock_tree_tb_top;
  import ctp_pkg::*;
  logic sys_clk_i = 1'h0, rst_i = 1'h1, slow_clk_i = 1'h0;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'h0, avs_write_i = 1'h0;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, d;
  logic [3:0] avs_byteenable_i = 4'hF, sdiv = 4'h0;
  logic avs_waitrequest_o, osc_enable_o, pll1_on_o, pll2_on_o, irq_o;
  logic [7:0] pll1_mul_o, pll1_div_o, pll2_div_o;
  logic [10:0] pll2_mul_o;
  logic [2:0] usb_div_factor_o, master_ratio_o;
  logic [1:0] master_src_o, pll1_halve_factor_o, prog_clk_en_o;
  logic [1:0] pll1_range_o, pll2_range_o;
  logic [6:0] master_presc_o;
  logic [5:0] prog_src_o;
  logic [13:0] prog_presc_o;
  logic [18:0] periph_clk_en_o;
  int bad_count = 0, total_checks = 0;
  ctp_clock_tree i_ctp_clock_tree (
    .sys_clk_i, .rst_i, .slow_clk_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
    .avs_waitrequest_o, .osc_enable_o, .pll1_on_o, .pll1_mul_o,
    .pll1_div_o, .pll1_range_o, .pll2_on_o, .pll2_mul_o, .pll2_div_o,
    .pll2_range_o, .usb_div_factor_o, .master_src_o, .master_presc_o,
    .master_ratio_o, .pll1_halve_factor_o, .prog_clk_en_o, .prog_src_o,
    .prog_presc_o, .periph_clk_en_o, .irq_o
  );
  always #4 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i)
  begin
    sdiv <= sdiv + 4'h1;
    if (sdiv[2:0] == 3'h7) slow_clk_i <= ~slow_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    @(negedge sys_clk_i);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= v;
    avs_write_i <= w;
    avs_read_i <= ~w;
    do
    begin
      @(posedge sys_clk_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'h0 && n < 20);
    d = avs_readdata_o;
    avs_write_i <= 1'h0;
    avs_read_i <= 1'h0;
    @(negedge sys_clk_i);
    if (n >= 20)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t bus hang", $time);
      wrap_up();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bus(1'h1, a, v);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, e);
    bus(1'h0, a, 32'h0);
    chk(d & m, e);
  endtask
  task automatic ticks(input int k);
    repeat (k) @(posedge slow_clk_i);
    repeat (6) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(32'(master_src_o), 32'(SRC_MAIN));
    chk(32'(master_presc_o), 32'(FACT_ONE));
    chk(32'({master_ratio_o, pll1_halve_factor_o}), 32'h5);
    chk(32'({prog_clk_en_o, periph_clk_en_o, pll1_on_o}), 32'h0);
    chk(32'({pll1_div_o, pll2_div_o, pll2_on_o}), 32'h0);
    rchk(OFF_SR, 32'hFFFFFFFF, 32'h8);
    rchk(8'h7C, 32'hFFFFFFFF, 32'h0);
    ticks(1);
    rchk(OFF_SR, 32'h1, 32'h1);
    chk(32'(osc_enable_o), 32'h1);
    wr(OFF_IER, 32'h1);
    chk(32'(irq_o), 32'h1);
    wr(OFF_IDR, 32'h1);
    chk(32'(irq_o), 32'h0);
    wr(OFF_MOR, 32'h0);
    chk(32'(osc_enable_o), 32'h0);
    rchk(OFF_SR, 32'h1, 32'h0);
    wr(OFF_MOR, 32'h101);
    ticks(3);
    rchk(OFF_SR, 32'h1, 32'h1);
    chk(32'(osc_enable_o), 32'h1);
    $display("reset test done");
  endtask
  task automatic t_periph;
    wr(OFF_PCER, 32'h40110);
    chk(32'(periph_clk_en_o), 32'h40110);
    wr(OFF_PCDR, 32'h10);
    chk(32'(periph_clk_en_o), 32'h40100);
    wr(OFF_PCER, 32'h0);
    rchk(OFF_PCSR, 32'hFFFFFFFF, 32'h40100);
    $display("periph test done");
  endtask
  task automatic t_pll;
    ticks(1);
    wr(OFF_PLL1, 32'h00040805);
    chk(32'({pll1_on_o, pll1_mul_o, pll1_div_o}), 32'h10405);
    ticks(8);
    rchk(OFF_SR, 32'h2, 32'h0);
    ticks(1);
    rchk(OFF_SR, 32'h2, 32'h2);
    wr(OFF_PLL2, 32'h27FF0805);
    chk(32'({pll2_on_o, pll2_mul_o, pll2_div_o}), 32'hFFF05);
    ticks(9);
    for (int i = 0; i < 3; i++)
    begin
      wr(OFF_PLL2, 32'h07FF0805 | (32'(i) << 28));
      chk(32'(usb_div_factor_o), 32'h1 << i);
    end
    rchk(OFF_SR, 32'h4, 32'h4);
    wr(OFF_PLL2, 32'h07FFC800);
    chk(32'(pll2_on_o), 32'h0);
    chk(32'(pll2_range_o), 32'h3);
    rchk(OFF_SR, 32'h4, 32'h0);
    $display("pll test done");
  endtask
  task automatic t_master;
    wr(OFF_MCKR, 32'h0D);
    rchk(OFF_SR, 32'h8, 32'h0);
    chk(32'(master_presc_o), 32'h8);
    ticks(5);
    rchk(OFF_SR, 32'h8, 32'h8);
    for (int i = 0; i < 4; i++)
    begin
      wr(OFF_MCKR, 32'h0D | (32'(i) << 8));
      chk(32'(master_ratio_o), (i == 3) ? 32'h3 : 32'h1 << i);
    end
    wr(OFF_MCKR, 32'h100D);
    chk(32'(pll1_halve_factor_o), 32'h2);
    rchk(OFF_SR, 32'h2, 32'h2);
    wr(OFF_MCKR, 32'h0E);
    ticks(5);
    chk(32'(master_src_o), 32'(SRC_PLL1));
    wr(OFF_PLL1, 32'h00054805);
    rchk(OFF_SR, 32'hA, 32'h0);
    chk(32'(master_src_o), 32'(SRC_MAIN));
    chk(32'(pll1_range_o), 32'h1);
    ticks(9);
    rchk(OFF_SR, 32'h2, 32'h2);
    ticks(5);
    rchk(OFF_SR, 32'h8, 32'h8);
    $display("master test done");
  endtask
  task automatic t_prog;
    wr(OFF_PCK0, 32'h15);
    chk(32'({prog_src_o[2:0], prog_presc_o[6:0]}), 32'hA0);
    wr(OFF_SCER, 32'h100);
    rchk(OFF_SCSR, 32'h300, 32'h100);
    ticks(3);
    rchk(OFF_SR, 32'h300, 32'h100);
    wr(OFF_SCDR, 32'h100);
    rchk(OFF_SR, 32'h100, 32'h0);
    chk(32'(prog_clk_en_o), 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      wr(OFF_PCK1, (i == 4) ? 32'h100 : 32'(i));
      chk(32'(prog_src_o[5:3]), 32'(i));
    end
    $display("prog test done");
  endtask
  initial
  begin
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    t_reset();
    t_periph();
    t_pll();
    t_master();
    t_prog();
    wrap_up();
  end
endmodule // ctp_clock_tree_tb_top
